/* File: rtl/spr_gen.sv */
// Internal test signal generator, one new word per sample strobe.
// Assumes the strobe marks sample boundaries of the audio stream.
`timescale 1ns/10ps
module spr_gen #(
    parameter int W = 24
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                smp_tick,
    input  wire logic [12:0]         src_sel,
    output logic signed [W-1:0]      gen_word,
    output logic                     gen_hit
);
    logic [31:0] ph100_r, ph1k_r, ph10k_r, phsw_r, swinc_r;
    logic [31:0] lf1_r, lf2_r;
    logic signed [W-1:0] pk1_r, pk2_r;

    // ************************************************************
    // Phase accumulators, noise shift registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph100_r <= 32'h0;
            ph1k_r  <= 32'h0;
            ph10k_r <= 32'h0;
            phsw_r  <= 32'h0;
            swinc_r <= 32'h0;
            lf1_r   <= spr_pkg::LFSR1_SEED;
            lf2_r   <= spr_pkg::LFSR2_SEED;
            pk1_r   <= '0;
            pk2_r   <= '0;
        end else if (smp_tick) begin
            ph100_r <= ph100_r + spr_pkg::PH_100;
            ph1k_r  <= ph1k_r + spr_pkg::PH_1K;
            ph10k_r <= ph10k_r + spr_pkg::PH_10K;
            swinc_r <= swinc_r + spr_pkg::PH_SWEEP_STEP;
            phsw_r  <= phsw_r + swinc_r;
            lf1_r   <= {lf1_r[30:0], 1'b0} ^ (lf1_r[31] ? spr_pkg::LFSR_TAPS : 32'h0);
            lf2_r   <= {lf2_r[30:0], 1'b0} ^ (lf2_r[31] ? spr_pkg::LFSR_TAPS : 32'h0);
            // Leaky one-pole low-pass as pink approximation
            pk1_r   <= pk1_r - (pk1_r >>> spr_pkg::PINK_SHIFT)
                       + ($signed(lf1_r[W-1:0]) >>> spr_pkg::PINK_SHIFT);
            pk2_r   <= pk2_r - (pk2_r >>> spr_pkg::PINK_SHIFT)
                       + ($signed(lf2_r[W-1:0]) >>> spr_pkg::PINK_SHIFT);
        end
    end

    // Square tones from phase MSB
    function automatic logic signed [W-1:0] sq(input logic b);
        sq = b ? {1'b1, {(W-1){1'b0}}} + 1'b1 : {1'b0, {(W-1){1'b1}}};
    endfunction

    wire dip = ph100_r[31 - spr_pkg::DIP_BIT[2:0]] && ph100_r[31];

    always_comb begin
        gen_hit  = 1'b1;
        unique case (src_sel)
            spr_pkg::SRC_SILENCE:  gen_word = '0;
            spr_pkg::SRC_SWEEP:    gen_word = sq(phsw_r[31]);
            spr_pkg::SRC_TONE_100: gen_word = sq(ph100_r[31]);
            spr_pkg::SRC_TONE_1K:  gen_word = sq(ph1k_r[31]);
            spr_pkg::SRC_TONE_10K: gen_word = sq(ph10k_r[31]);
            spr_pkg::SRC_TONE_DIP: gen_word = dip ? sq(ph1k_r[31]) >>> spr_pkg::DIP_SHIFT
                                                  : sq(ph1k_r[31]);
            spr_pkg::SRC_WHITE_1:  gen_word = $signed(lf1_r[W-1:0]);
            spr_pkg::SRC_WHITE_2:  gen_word = $signed(lf2_r[W-1:0]);
            spr_pkg::SRC_PINK_1:   gen_word = pk1_r;
            spr_pkg::SRC_PINK_2:   gen_word = pk2_r;
            default: begin
                gen_word = '0;
                gen_hit  = 1'b0;
            end
        endcase
    end
endmodule

/* File: rtl/spr_mixer.sv */
// Stereo pair remedy mixer: remedies for one adjacent pair, plus
// generator sources and a two-entry output buffer toward the matrix.
// Assumes input and matrix streams share clk_sys; samples signed.
`timescale 1ns/10ps
module spr_mixer #(
    parameter int W = spr_pkg::SAMPLE_W
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire spr_pkg::spr_pair_s    in_pair,
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire spr_pkg::spr_remedy_e  rem_left,
    input  wire spr_pkg::spr_remedy_e  rem_right,
    input  wire logic [12:0]           src_left,
    input  wire logic [12:0]           src_right,
    output spr_pkg::spr_pair_s         out_pair,
    output logic                       out_valid,
    input  wire logic                  out_ready
);
    // ************************************************************
    // Remedy latch on sample boundary
    // ************************************************************
    spr_pkg::spr_remedy_e rem_l_r, rem_r_r;
    wire take = in_valid && in_ready;

    // settings taken only with a sample
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rem_l_r <= spr_pkg::SPR_NORMAL;
            rem_r_r <= spr_pkg::SPR_NORMAL;
        end else if (take) begin
            rem_l_r <= rem_left;
            rem_r_r <= rem_right;
        end
    end
    wire spr_pkg::spr_remedy_e rl = take ? rem_left : rem_l_r;
    wire spr_pkg::spr_remedy_e rr = take ? rem_right : rem_r_r;

    // ************************************************************
    // Pair arithmetic
    // ************************************************************
    // left is first, right is second, pair only
    wire signed [W-1:0] lft = in_pair.left;
    wire signed [W-1:0] rgt = in_pair.right;
    wire signed [W:0]   sum_w = {lft[W-1], lft} + {rgt[W-1], rgt};
    wire signed [W:0]   dif_w = {lft[W-1], lft} - {rgt[W-1], rgt};
    // halving; range of W+1 halved always fits W bits
    wire signed [W-1:0] sum_h = sum_w[W:1];
    wire signed [W-1:0] dif_h = dif_w[W:1];

    function automatic logic signed [W-1:0] pick(
        input spr_pkg::spr_remedy_e r,
        input logic signed [W-1:0] own,
        input logic signed [W-1:0] mate,
        input logic signed [W-1:0] s,
        input logic signed [W-1:0] d);
        unique case (r)
            spr_pkg::SPR_NORMAL: pick = own;
            spr_pkg::SPR_SWAP:   pick = mate;
            spr_pkg::SPR_SUM:    pick = s;
            spr_pkg::SPR_DIFF:   pick = d;
        endcase
    endfunction

    wire signed [W-1:0] rem_lo = pick(rl, lft, rgt, sum_h, dif_h);
    wire signed [W-1:0] rem_ro = pick(rr, rgt, lft, sum_h, dif_h);

    // ************************************************************
    // Generator substitution per channel
    // ************************************************************
    logic signed [W-1:0] gw_l, gw_r;
    logic                gh_l, gh_r;

    spr_gen #(.W(W)) u_gen_l (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .smp_tick (take),
        .src_sel  (src_left),
        .gen_word (gw_l),
        .gen_hit  (gh_l)
    );
    spr_gen #(.W(W)) u_gen_r (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .smp_tick (take),
        .src_sel  (src_right),
        .gen_word (gw_r),
        .gen_hit  (gh_r)
    );

    spr_pkg::spr_pair_s mix_pair;
    assign mix_pair.left  = gh_l ? gw_l : rem_lo;
    assign mix_pair.right = gh_r ? gw_r : rem_ro;

    // ************************************************************
    // Output register and buffer
    // ************************************************************
    spr_pkg::spr_pair_s stage_r;
    logic               stage_v_r;
    logic               buf_rdy;
    spr_pkg::spr_pair_s buf_d;
    logic               buf_v;
    spr_pkg::spr_pair_s out_pair_r;
    logic               out_valid_r;
    wire                out_load = !out_valid_r || out_ready;

    // ************************************************************
    // Input ready from a flop
    // ************************************************************
    logic [1:0] fill_r;
    logic [1:0] fill_nxt;
    logic       in_ready_r;
    logic       in_ready_nxt;
    wire        stage_v_nxt = in_ready_r ? in_valid : stage_v_r;
    wire        buf_push    = stage_v_r && buf_rdy;
    wire        buf_pop     = buf_v && out_load;

    // mirror buffer fill, predict next ready
    assign fill_nxt     = fill_r + {1'b0, buf_push} - {1'b0, buf_pop};
    assign in_ready_nxt = !stage_v_nxt || (fill_nxt != spr_pkg::BUF_FULL);

    // Ready register, open during reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill_r     <= 2'h0;
            in_ready_r <= 1'b1;
        end else begin
            fill_r     <= fill_nxt;
            in_ready_r <= in_ready_nxt;
        end
    end

    // Accept when stage empty or draining
    assign in_ready = in_ready_r;

    // Pipeline stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_r   <= '0;
            stage_v_r <= 1'b0;
        end else if (in_ready) begin
            stage_r   <= mix_pair;
            stage_v_r <= in_valid;
        end
    end

    spr_skid #(.W(2*W)) u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (stage_r),
        .in_valid  (stage_v_r),
        .in_ready  (buf_rdy),
        .out_data  (buf_d),
        .out_valid (buf_v),
        .out_ready (out_load)
    );

    // Registered output toward matrix
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_pair_r  <= '0;
            out_valid_r <= 1'b0;
        end else if (out_load) begin
            out_pair_r  <= buf_d;
            out_valid_r <= buf_v;
        end
    end
    assign out_pair  = out_pair_r;
    assign out_valid = out_valid_r;

    // ************************************************************
    // Checks
    // ************************************************************
    // Floor halves built from halved operands, apart from the adder path
    wire signed [W-1:0] chk_sum = (lft >>> 1) + (rgt >>> 1) + $signed({1'b0, lft[0] & rgt[0]});
    wire signed [W-1:0] chk_dif = (lft >>> 1) - (rgt >>> 1) - $signed({1'b0, ~lft[0] & rgt[0]});

    a_normal_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_NORMAL && !gh_l) |=> stage_r.left == $past(lft))
        else $error("normal left not passed");
    a_swap_mate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SWAP && !gh_l) |=> stage_r.left == $past(rgt))
        else $error("swap left wrong");
    a_swap_cross: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SWAP && rem_right == spr_pkg::SPR_SWAP
         && !gh_l && !gh_r)
        |=> stage_r.left == $past(rgt) && stage_r.right == $past(lft))
        else $error("pair not crossed");
    a_swap_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SWAP && rem_right == spr_pkg::SPR_NORMAL
         && !gh_l && !gh_r) |=> stage_r.left == stage_r.right)
        else $error("one-sided swap mismatch");
    a_sum_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_right == spr_pkg::SPR_SUM && !gh_r)
        |=> stage_r.right == $past(chk_sum))
        else $error("sum wrong");
    a_sum_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SUM && rem_right == spr_pkg::SPR_SUM
         && !gh_l && !gh_r) |=> stage_r.left == stage_r.right)
        else $error("sum outputs differ");
    a_diff_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_right == spr_pkg::SPR_DIFF && !gh_r)
        |=> stage_r.right == $past(chk_dif))
        else $error("difference wrong");
    a_partner_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_DIFF && rem_right == spr_pkg::SPR_NORMAL
         && !gh_r) |=> stage_r.right == $past(rgt))
        else $error("partner altered");
    a_gen_silence: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && src_left == spr_pkg::SRC_SILENCE) |=> stage_r.left == '0)
        else $error("silence not zero");
    a_no_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (out_valid && !out_ready) |=> out_valid && $stable(out_pair))
        else $error("output word dropped");
    a_diff_left: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_DIFF && !gh_l)
        |=> stage_r.left == $past(chk_dif))
        else $error("left difference wrong");
    a_sum_left: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SUM && !gh_l)
        |=> stage_r.left == $past(chk_sum))
        else $error("left sum wrong");
    a_normal_right: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_right == spr_pkg::SPR_NORMAL && !gh_r)
        |=> stage_r.right == $past(rgt))
        else $error("normal right not passed");
    a_swap_right: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_right == spr_pkg::SPR_SWAP && !gh_r)
        |=> stage_r.right == $past(lft))
        else $error("swap right wrong");
    a_sum_partner: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (take && rem_left == spr_pkg::SPR_SUM && rem_right == spr_pkg::SPR_NORMAL
         && !gh_r) |=> stage_r.right == $past(rgt))
        else $error("partner altered by sum");
    a_ready_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_ready == (!stage_v_r || buf_rdy))
        else $error("ready flop out of step");

    c_swap_both: cover property (@(posedge clk_sys)
        take && rem_left == spr_pkg::SPR_SWAP && rem_right == spr_pkg::SPR_SWAP);
    c_sum_one: cover property (@(posedge clk_sys) take && rem_left == spr_pkg::SPR_SUM);
    c_gen_noise: cover property (@(posedge clk_sys) take && src_right == spr_pkg::SRC_PINK_2);
    c_stall: cover property (@(posedge clk_sys) out_valid && !out_ready ##1 !in_ready);
    c_diff_right: cover property (@(posedge clk_sys) take && rem_right == spr_pkg::SPR_DIFF);
endmodule

/* File: rtl/spr_pkg.sv */
// Shared types and constants for the stereo pair remedy mixer.
// Assumes one sample clock domain; samples are signed two's complement.
package spr_pkg;

    // ************************************************************
    // Widths and remedy codes
    // ************************************************************
    localparam int SAMPLE_W = 24;
    localparam int SRC_W    = 13;

    typedef enum logic [1:0] {
        SPR_NORMAL = 2'b00,
        SPR_SWAP   = 2'b01,
        SPR_SUM    = 2'b10,
        SPR_DIFF   = 2'b11
    } spr_remedy_e;

    // ************************************************************
    // Reserved generator source numbers
    // ************************************************************
    localparam logic [12:0] SRC_SILENCE   = 13'h1001;
    localparam logic [12:0] SRC_SWEEP     = 13'h1002;
    localparam logic [12:0] SRC_TONE_100  = 13'h1003;
    localparam logic [12:0] SRC_TONE_1K   = 13'h1004;
    localparam logic [12:0] SRC_TONE_10K  = 13'h1005;
    localparam logic [12:0] SRC_TONE_DIP  = 13'h1006;
    localparam logic [12:0] SRC_WHITE_1   = 13'h1007;
    localparam logic [12:0] SRC_WHITE_2   = 13'h1008;
    localparam logic [12:0] SRC_PINK_1    = 13'h1009;
    localparam logic [12:0] SRC_PINK_2    = 13'h100a;

    // ************************************************************
    // Generator timing at a 48 kHz sample rate
    // ************************************************************
    localparam logic [31:0] PH_100  = 32'h0088_8889;  // 100 Hz phase step
    localparam logic [31:0] PH_1K   = 32'h0555_5555;  // 1 kHz phase step
    localparam logic [31:0] PH_10K  = 32'h3555_5555;  // 10 kHz phase step
    localparam logic [31:0] PH_SWEEP_STEP = 32'h0000_0100;
    localparam logic [31:0] LFSR1_SEED = 32'hace1_2468;
    localparam logic [31:0] LFSR2_SEED = 32'h1357_bdf9;
    localparam logic [31:0] LFSR_TAPS  = 32'h8020_0003;
    localparam logic [2:0]  DIP_BIT    = 3'h7;       // Dip when phase MSB and bit 24 both set
    localparam int          DIP_SHIFT  = 3;          // Dip depth as a right shift
    localparam int          PINK_SHIFT = 4;          // Pink filter leak as a shift

    // ************************************************************
    // Output buffer occupancy
    // ************************************************************
    localparam logic [1:0]  BUF_FULL   = 2'h2;

    // ************************************************************
    // Carrier of one stereo pair
    // ************************************************************
    typedef struct packed {
        logic signed [SAMPLE_W-1:0] left;
        logic signed [SAMPLE_W-1:0] right;
    } spr_pair_s;

endpackage

/* File: rtl/spr_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module spr_skid #(
    parameter int W = 48
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem_r [2];
    logic         wp_r;
    logic         rp_r;
    logic [1:0]   cnt_r;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    // ************************************************************
    // Flags and head
    // ************************************************************
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];

    // Pointers and occupancy
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) wp_r <= ~wp_r;
            if (pop)  rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) mem_r[wp_r] <= in_data;
    end

    a_skid_no_overflow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_r <= 2'h2) else $error("buffer over two entries");
endmodule

/* File: verification/spr_matrix_model.sv */
// Matrix side model: takes result pairs with a settable stall pattern.
// Assumes the mixer's output stream runs on clk_sys.
`timescale 1ns/10ps
module spr_matrix_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [1:0] stall_mode,
    output logic            out_ready
);
    logic [1:0] tick_r;

    // Free running stall pattern counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 2'h0;
        end else begin
            tick_r <= tick_r + 2'h1;
        end
    end

    // whole pair taken
    // Ready: mode 0 always, mode 1 one cycle in four, mode 2 never
    assign out_ready = (stall_mode == 2'h0) || ((stall_mode == 2'h1) && (tick_r == 2'h0));
endmodule

/* File: verification/spr_mixer_tb.sv */
// Self-checking bench for the stereo pair remedy mixer.
// Assumes the matrix side model and one 10 MHz clock.
`timescale 1ns/10ps
module spr_mixer_tb;
    localparam int W = spr_pkg::SAMPLE_W;
    logic                 clk_sys;
    logic                 rst_n;
    logic                 in_valid;
    logic                 in_ready;
    logic                 out_valid;
    logic                 out_ready;
    spr_pkg::spr_pair_s   in_pair;
    spr_pkg::spr_pair_s   out_pair;
    spr_pkg::spr_remedy_e rem_left;
    spr_pkg::spr_remedy_e rem_right;
    logic [12:0]          src_left;
    logic [12:0]          src_right;
    logic [1:0]           stall_mode;
    int                   error_cnt;
    int                   check_count;
    spr_pkg::spr_pair_s   exp_q[$];
    spr_pkg::spr_pair_s   got_q[$];

    // ****************************************
    // Clock, instances, collection
    // ****************************************
    always #50 clk_sys = ~clk_sys;

    spr_mixer dut (.clk_sys(clk_sys), .rst_n(rst_n), .in_pair(in_pair), .in_valid(in_valid),
        .in_ready(in_ready), .rem_left(rem_left), .rem_right(rem_right), .src_left(src_left),
        .src_right(src_right), .out_pair(out_pair), .out_valid(out_valid),
        .out_ready(out_ready));
    spr_matrix_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .stall_mode(stall_mode),
        .out_ready(out_ready));

    // Words taken by the matrix, seen between edges
    always @(negedge clk_sys) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back(out_pair);
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected channel word, halves floored
    function automatic logic [W-1:0] rv(input logic [1:0] r, input logic [W-1:0] own,
        input logic [W-1:0] mate, input spr_pkg::spr_pair_s p);
        logic [W:0] s;
        logic [W:0] d;
        s = {p.left[W-1], p.left} + {p.right[W-1], p.right};
        d = {p.left[W-1], p.left} - {p.right[W-1], p.right};
        case (r)
            2'h0: return own;
            2'h1: return mate;
            2'h2: return s[W:1];
            default: return d[W:1];
        endcase
    endfunction

    // Caller sits at a rising edge; returns at the edge that takes the sample
    task automatic send(input spr_pkg::spr_pair_s p, input logic [1:0] rl, input logic [1:0] rr,
        input logic [12:0] sl, input logic [12:0] sr, input bit push);
        int n;
        spr_pkg::spr_pair_s e;
        n = 0;
        in_pair <= p;
        rem_left <= spr_pkg::spr_remedy_e'(rl);
        rem_right <= spr_pkg::spr_remedy_e'(rr);
        src_left <= sl;
        src_right <= sr;
        in_valid <= 1'b1;
        @(negedge clk_sys);
        while (in_ready !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk(48'(in_ready), 48'h1);
        @(posedge clk_sys);
        e.left = rv(rl, p.left, p.right, p);
        e.right = rv(rr, p.right, p.left, p);
        if (push) exp_q.push_back(e);
    endtask

    task automatic idle();
        in_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        chk(48'(got_q.size()), 48'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0) begin
            chk(got_q.pop_front(), exp_q.pop_front());
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // every remedy pairing, extremes, back to back
    task automatic test_remedies();
        spr_pkg::spr_pair_s d[3];
        d[0] = {24'h123455, 24'hfedcb9};
        d[1] = {24'h7fffff, 24'h800000};
        d[2] = {24'h800000, 24'h7fffff};
        stall_mode <= 2'h0;
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 16; c++) begin
                send(d[k], 2'(c >> 2), 2'(c), 13'h1000, 13'h100b, 1'b1);
            end
        end
        idle();
        drain();
    endtask

    // Buffering: matrix stalls until input is refused, then drains slowly
    task automatic test_stall();
        fork
            begin
                for (int i = 0; i < 8; i++) begin
                    send({24'(i * 24'h111111), 24'(-i)}, 2'(i), 2'(3 - i), 13'h0, 13'h0, 1'b1);
                end
                idle();
            end
        join_none
        stall_mode <= 2'h2;
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(48'(in_ready), 48'h0);
        @(posedge clk_sys);
        stall_mode <= 2'h1;
        wait fork;
        drain();
    endtask

    // every generator code, on alternating channels
    task automatic test_gen();
        spr_pkg::spr_pair_s p;
        spr_pkg::spr_pair_s w;
        logic [12:0]        code;
        bit                 lft;
        bit                 diff;
        int                 n;
        p = {24'h2468ac, 24'h13579b};
        stall_mode <= 2'h0;
        for (int k = 0; k < 10; k++) begin
            code = spr_pkg::SRC_SILENCE + 13'(k);
            lft = (k % 2 == 0);
            diff = 1'b0;
            n = 0;
            repeat (4) send(p, 2'h0, 2'h0, lft ? code : 13'h0, lft ? 13'h0 : code, 1'b0);
            idle();
            while (got_q.size() < 4 && n < 100) begin
                @(posedge clk_sys);
                n++;
            end
            chk(48'(got_q.size()), 48'h4);
            while (got_q.size() > 0) begin
                w = got_q.pop_front();
                chk(48'(lft ? w.right : w.left), 48'(lft ? p.right : p.left));
                if (k == 0) chk(48'(lft ? w.left : w.right), 48'h0);
                diff |= ((lft ? w.left : w.right) !== (lft ? p.left : p.right));
            end
            if (k > 0) chk(48'(diff), 48'h1);
        end
    endtask

    // Reset in mid-flight drops buffered words
    task automatic test_reset();
        stall_mode <= 2'h2;
        send({24'h000011, 24'h000022}, 2'h0, 2'h0, 13'h0, 13'h0, 1'b0);
        idle();
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b0;
        @(negedge clk_sys);
        chk({46'h0, out_valid, in_ready}, 48'h1);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        stall_mode <= 2'h0;
        repeat (10) @(posedge clk_sys);
        chk(48'(got_q.size()), 48'h0);
    endtask

    // ****************************************
    // Sequence, watchdog, verdict
    // ****************************************
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_pair = '0;
        rem_left = spr_pkg::SPR_NORMAL;
        rem_right = spr_pkg::SPR_NORMAL;
        src_left = 13'h0;
        src_right = 13'h0;
        stall_mode = 2'h0;
        error_cnt = 0;
        check_count = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        test_remedies();
        test_stall();
        test_gen();
        test_reset();
        test_remedies();
        finish_test();
    end

    // Tests need about 300 cycles; cut off at 30000
    initial begin
        #3000000;
        error_cnt++;
        finish_test();
    end
endmodule
